// [monitor_bank_params.svh]
// Register offsets, field positions and reset values of the drive monitor bank
// Behaviour
// - Monitor words are read only; writes from the master change nothing.
// - Keypad status: setting error, fault, programming mode, two-bit panel type.
// - Fault word one bits 0-7: fuse, three undervoltages, unused, earth, current, overvoltage.
// - Fault word one bits 8-B: heatsink prealarm, heatsink trip, motor and drive overload.
// - Fault word one bits C-F: overtorque 1 and 2, brake transistor, brake resistor hot.
// - Fault word two bits 0-4: external faults terminals S3-S7; bits 5,6 unused.
// - Fault word two bits 7-B: overspeed, deviation, encoder loss, input phase, output phase.
// - Fault word two: C motor prealarm, E error flag, F motor overheat trip.
// - Fault word three: 0 serial error, 1 option bus error, 4 control fault.
// - Fault word three: 6 option external, 7 feedback loss, 8-9 undertorque, A slip brake.
// - Alarm word one bits 0-5: undervoltage, overvoltage, heatsink, heat input, overtorque.
// - Alarm word one: bit 6 run direction conflict, bit 7 output blocked.
// - Alarm word one: bits 8-C external alarms S3-S7, D-E unused, F overspeed.
// - Alarm word two bits 1-4,6,7: deviation, encoder, keypad, serial, overloads.
// - Alarm word two bit 5 is set while the serial link waits on standby.
`ifndef MONITOR_BANK_PARAMS_SVH
`define MONITOR_BANK_PARAMS_SVH
`define ADDR_RUN_STATUS 16'h0010
`define ADDR_KEYPAD 16'h0011
`define ADDR_SET_ERR_NUM 16'h0012
`define ADDR_UNUSED 16'h0013
`define ADDR_FAULT_ONE 16'h0014
`define ADDR_FAULT_TWO 16'h0015
`define ADDR_FAULT_THREE 16'h0016
`define ADDR_BOARD_ONE 16'h0017
`define ADDR_BOARD_TWO 16'h0018
`define ADDR_ALARM_ONE 16'h0019
`define ADDR_ALARM_TWO 16'h001a
`define RUN_STATUS_MASK 16'h00ff
`define BOARD_ONE_MASK 16'h006c
`define BOARD_TWO_MASK 16'h000f
`define SET_ERR_NUM_MASK 16'hffff
`define WORD_RESET 16'h0000
`endif

// [monitor_bank_pkg.sv]
// Types shared by the drive monitor bank
`default_nettype none
package monitor_bank_pkg;
	typedef struct packed {
		logic setting_error;
		logic in_fault;
		logic programming_mode;
		logic [1:0] panel_type;
	} keypad_src_type;
	typedef struct packed {
		logic dc_fuse_blown;
		logic bus_low_voltage_trip;
		logic control_supply_low;
		logic inrush_circuit_fault;
		logic earth_fault;
		logic current_trip;
		logic dc_bus_high_voltage;
		logic heatsink_heat_prealarm;
		logic heatsink_overheat_trip;
		logic motor_thermal_trip;
		logic drive_thermal_trip;
		logic torque_high_1;
		logic torque_high_2;
		logic brake_transistor_fault;
		logic brake_resistor_hot;
		logic [4:0] ext_fault_input;
		logic excess_speed;
		logic speed_error;
		logic encoder_disconnected;
		logic input_phase_loss;
		logic output_phase_open;
		logic motor_heat_prealarm;
		logic general_error;
		logic motor_heat_trip;
		logic serial_comm_error;
		logic option_bus_error;
		logic control_loop_fault;
		logic option_card_external_fault;
		logic pid_feedback_loss;
		logic torque_low_1;
		logic torque_low_2;
		logic slip_brake_thermal;
	} fault_src_type;
	typedef struct packed {
		logic dc_bus_low_voltage;
		logic dc_bus_high_voltage;
		logic heatsink_heat_prealarm;
		logic drive_heat_alarm_input;
		logic torque_high_1;
		logic torque_high_2;
		logic fwd_rev_conflict;
		logic output_blocked;
		logic [4:0] ext_alarm_input;
		logic excess_speed;
		logic speed_error;
		logic encoder_disconnected;
		logic keypad_detached;
		logic serial_comm_error;
		logic link_standby;
		logic motor_thermal_trip;
		logic drive_thermal_trip;
	} alarm_src_type;
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_type;
	typedef struct packed {
		logic valid;
		logic error;
		logic [15:0] rdata;
	} reg_rsp_type;
endpackage
`default_nettype wire

// [drive_monitor_status_bank.sv]
// Read-only monitor word bank of the drive, served to the protocol engine
`include "monitor_bank_params.svh"
`default_nettype none
module drive_monitor_status_bank #(
	parameter int WORD_WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire monitor_bank_pkg::reg_req_type req,
	output var monitor_bank_pkg::reg_rsp_type rsp,
	input wire logic [WORD_WIDTH-1:0] run_status_src,
	input wire logic [WORD_WIDTH-1:0] setting_error_number_src,
	input wire logic [WORD_WIDTH-1:0] board_fault_one_src,
	input wire logic [WORD_WIDTH-1:0] board_fault_two_src,
	input wire monitor_bank_pkg::keypad_src_type keypad_src,
	input wire monitor_bank_pkg::fault_src_type fault_src,
	input wire monitor_bank_pkg::alarm_src_type alarm_src
);
	import monitor_bank_pkg::*;

	// Sources are logic on sys_clk, so they are sampled without synchronisers
	logic [WORD_WIDTH-1:0] run_status_word;
	logic [WORD_WIDTH-1:0] keypad_word;
	logic [WORD_WIDTH-1:0] set_err_word;
	logic [WORD_WIDTH-1:0] fault_one_word;
	logic [WORD_WIDTH-1:0] fault_two_word;
	logic [WORD_WIDTH-1:0] fault_three_word;
	logic [WORD_WIDTH-1:0] board_one_word;
	logic [WORD_WIDTH-1:0] board_two_word;
	logic [WORD_WIDTH-1:0] alarm_one_word;
	logic [WORD_WIDTH-1:0] alarm_two_word;

	logic sel_run_status;
	logic sel_keypad;
	logic sel_set_err;
	logic sel_unused;
	logic sel_fault_one;
	logic sel_fault_two;
	logic sel_fault_three;
	logic sel_board_one;
	logic sel_board_two;
	logic sel_alarm_one;
	logic sel_alarm_two;

	logic [WORD_WIDTH-1:0] pick_run_status;
	logic [WORD_WIDTH-1:0] pick_keypad;
	logic [WORD_WIDTH-1:0] pick_set_err;
	logic [WORD_WIDTH-1:0] pick_fault_one;
	logic [WORD_WIDTH-1:0] pick_fault_two;
	logic [WORD_WIDTH-1:0] pick_fault_three;
	logic [WORD_WIDTH-1:0] pick_board_one;
	logic [WORD_WIDTH-1:0] pick_board_two;
	logic [WORD_WIDTH-1:0] pick_alarm_one;
	logic [WORD_WIDTH-1:0] pick_alarm_two;

	logic [WORD_WIDTH-1:0] read_word;
	logic addr_hit;
	logic read_req;
	logic write_req;
	reg_rsp_type rsp_reg;
	reg_rsp_type rsp_next;

	// Run word: only the low byte carries flags
	assign run_status_word[0] = run_status_src[0];
	assign run_status_word[1] = run_status_src[1];
	assign run_status_word[2] = run_status_src[2];
	assign run_status_word[3] = run_status_src[3];
	assign run_status_word[4] = run_status_src[4];
	assign run_status_word[5] = run_status_src[5];
	assign run_status_word[6] = run_status_src[6];
	assign run_status_word[7] = run_status_src[7];
	assign run_status_word[8] = 1'b0;
	assign run_status_word[9] = 1'b0;
	assign run_status_word[10] = 1'b0;
	assign run_status_word[11] = 1'b0;
	assign run_status_word[12] = 1'b0;
	assign run_status_word[13] = 1'b0;
	assign run_status_word[14] = 1'b0;
	assign run_status_word[15] = 1'b0;

	// Keypad status
	assign keypad_word[0] = keypad_src.setting_error;
	assign keypad_word[1] = keypad_src.in_fault;
	assign keypad_word[2] = keypad_src.programming_mode;
	assign keypad_word[3] = keypad_src.panel_type[0];
	assign keypad_word[4] = keypad_src.panel_type[1];
	assign keypad_word[5] = 1'b0;
	assign keypad_word[6] = 1'b0;
	assign keypad_word[7] = 1'b0;
	assign keypad_word[8] = 1'b0;
	assign keypad_word[9] = 1'b0;
	assign keypad_word[10] = 1'b0;
	assign keypad_word[11] = 1'b0;
	assign keypad_word[12] = 1'b0;
	assign keypad_word[13] = 1'b0;
	assign keypad_word[14] = 1'b0;
	assign keypad_word[15] = 1'b0;

	assign set_err_word = setting_error_number_src & `SET_ERR_NUM_MASK;

	// Fault word one
	assign fault_one_word[0] = fault_src.dc_fuse_blown;
	assign fault_one_word[1] = fault_src.bus_low_voltage_trip;
	assign fault_one_word[2] = fault_src.control_supply_low;
	assign fault_one_word[3] = fault_src.inrush_circuit_fault;
	assign fault_one_word[4] = 1'b0;
	assign fault_one_word[5] = fault_src.earth_fault;
	assign fault_one_word[6] = fault_src.current_trip;
	assign fault_one_word[7] = fault_src.dc_bus_high_voltage;
	assign fault_one_word[8] = fault_src.heatsink_heat_prealarm;
	assign fault_one_word[9] = fault_src.heatsink_overheat_trip;
	assign fault_one_word[10] = fault_src.motor_thermal_trip;
	assign fault_one_word[11] = fault_src.drive_thermal_trip;
	assign fault_one_word[12] = fault_src.torque_high_1;
	assign fault_one_word[13] = fault_src.torque_high_2;
	assign fault_one_word[14] = fault_src.brake_transistor_fault;
	assign fault_one_word[15] = fault_src.brake_resistor_hot;

	// Fault word two; bit D has no defined meaning and reads zero
	assign fault_two_word[0] = fault_src.ext_fault_input[0];
	assign fault_two_word[1] = fault_src.ext_fault_input[1];
	assign fault_two_word[2] = fault_src.ext_fault_input[2];
	assign fault_two_word[3] = fault_src.ext_fault_input[3];
	assign fault_two_word[4] = fault_src.ext_fault_input[4];
	assign fault_two_word[5] = 1'b0;
	assign fault_two_word[6] = 1'b0;
	assign fault_two_word[7] = fault_src.excess_speed;
	assign fault_two_word[8] = fault_src.speed_error;
	assign fault_two_word[9] = fault_src.encoder_disconnected;
	assign fault_two_word[10] = fault_src.input_phase_loss;
	assign fault_two_word[11] = fault_src.output_phase_open;
	assign fault_two_word[12] = fault_src.motor_heat_prealarm;
	assign fault_two_word[13] = 1'b0;
	assign fault_two_word[14] = fault_src.general_error;
	assign fault_two_word[15] = fault_src.motor_heat_trip;

	// Fault word three
	assign fault_three_word[0] = fault_src.serial_comm_error;
	assign fault_three_word[1] = fault_src.option_bus_error;
	assign fault_three_word[2] = 1'b0;
	assign fault_three_word[3] = 1'b0;
	assign fault_three_word[4] = fault_src.control_loop_fault;
	assign fault_three_word[5] = 1'b0;
	assign fault_three_word[6] = fault_src.option_card_external_fault;
	assign fault_three_word[7] = fault_src.pid_feedback_loss;
	assign fault_three_word[8] = fault_src.torque_low_1;
	assign fault_three_word[9] = fault_src.torque_low_2;
	assign fault_three_word[10] = fault_src.slip_brake_thermal;
	assign fault_three_word[11] = 1'b0;
	assign fault_three_word[12] = 1'b0;
	assign fault_three_word[13] = 1'b0;
	assign fault_three_word[14] = 1'b0;
	assign fault_three_word[15] = 1'b0;

	// Board fault word one: only bits 2, 3, 5 and 6 are defined
	assign board_one_word[0] = 1'b0;
	assign board_one_word[1] = 1'b0;
	assign board_one_word[2] = board_fault_one_src[2];
	assign board_one_word[3] = board_fault_one_src[3];
	assign board_one_word[4] = 1'b0;
	assign board_one_word[5] = board_fault_one_src[5];
	assign board_one_word[6] = board_fault_one_src[6];
	assign board_one_word[7] = 1'b0;
	assign board_one_word[8] = 1'b0;
	assign board_one_word[9] = 1'b0;
	assign board_one_word[10] = 1'b0;
	assign board_one_word[11] = 1'b0;
	assign board_one_word[12] = 1'b0;
	assign board_one_word[13] = 1'b0;
	assign board_one_word[14] = 1'b0;
	assign board_one_word[15] = 1'b0;

	// Board fault word two: only the low nibble is defined
	assign board_two_word[0] = board_fault_two_src[0];
	assign board_two_word[1] = board_fault_two_src[1];
	assign board_two_word[2] = board_fault_two_src[2];
	assign board_two_word[3] = board_fault_two_src[3];
	assign board_two_word[4] = 1'b0;
	assign board_two_word[5] = 1'b0;
	assign board_two_word[6] = 1'b0;
	assign board_two_word[7] = 1'b0;
	assign board_two_word[8] = 1'b0;
	assign board_two_word[9] = 1'b0;
	assign board_two_word[10] = 1'b0;
	assign board_two_word[11] = 1'b0;
	assign board_two_word[12] = 1'b0;
	assign board_two_word[13] = 1'b0;
	assign board_two_word[14] = 1'b0;
	assign board_two_word[15] = 1'b0;

	// Alarm word one
	assign alarm_one_word[0] = alarm_src.dc_bus_low_voltage;
	assign alarm_one_word[1] = alarm_src.dc_bus_high_voltage;
	assign alarm_one_word[2] = alarm_src.heatsink_heat_prealarm;
	assign alarm_one_word[3] = alarm_src.drive_heat_alarm_input;
	assign alarm_one_word[4] = alarm_src.torque_high_1;
	assign alarm_one_word[5] = alarm_src.torque_high_2;
	assign alarm_one_word[6] = alarm_src.fwd_rev_conflict;
	assign alarm_one_word[7] = alarm_src.output_blocked;
	assign alarm_one_word[8] = alarm_src.ext_alarm_input[0];
	assign alarm_one_word[9] = alarm_src.ext_alarm_input[1];
	assign alarm_one_word[10] = alarm_src.ext_alarm_input[2];
	assign alarm_one_word[11] = alarm_src.ext_alarm_input[3];
	assign alarm_one_word[12] = alarm_src.ext_alarm_input[4];
	assign alarm_one_word[13] = 1'b0;
	assign alarm_one_word[14] = 1'b0;
	assign alarm_one_word[15] = alarm_src.excess_speed;

	// Alarm word two; the upper byte is not served by this bank and reads zero
	assign alarm_two_word[0] = 1'b0;
	assign alarm_two_word[1] = alarm_src.speed_error;
	assign alarm_two_word[2] = alarm_src.encoder_disconnected;
	assign alarm_two_word[3] = alarm_src.keypad_detached;
	assign alarm_two_word[4] = alarm_src.serial_comm_error;
	assign alarm_two_word[5] = alarm_src.link_standby;
	assign alarm_two_word[6] = alarm_src.motor_thermal_trip;
	assign alarm_two_word[7] = alarm_src.drive_thermal_trip;
	assign alarm_two_word[8] = 1'b0;
	assign alarm_two_word[9] = 1'b0;
	assign alarm_two_word[10] = 1'b0;
	assign alarm_two_word[11] = 1'b0;
	assign alarm_two_word[12] = 1'b0;
	assign alarm_two_word[13] = 1'b0;
	assign alarm_two_word[14] = 1'b0;
	assign alarm_two_word[15] = 1'b0;

	// Address decode, one select per word
	assign sel_run_status = (req.addr == `ADDR_RUN_STATUS);
	assign sel_keypad = (req.addr == `ADDR_KEYPAD);
	assign sel_set_err = (req.addr == `ADDR_SET_ERR_NUM);
	assign sel_unused = (req.addr == `ADDR_UNUSED);
	assign sel_fault_one = (req.addr == `ADDR_FAULT_ONE);
	assign sel_fault_two = (req.addr == `ADDR_FAULT_TWO);
	assign sel_fault_three = (req.addr == `ADDR_FAULT_THREE);
	assign sel_board_one = (req.addr == `ADDR_BOARD_ONE);
	assign sel_board_two = (req.addr == `ADDR_BOARD_TWO);
	assign sel_alarm_one = (req.addr == `ADDR_ALARM_ONE);
	assign sel_alarm_two = (req.addr == `ADDR_ALARM_TWO);

	// The unused word is a legal address but has no pick, so it reads zero
	assign addr_hit = sel_run_status
		| sel_keypad
		| sel_set_err
		| sel_unused
		| sel_fault_one
		| sel_fault_two
		| sel_fault_three
		| sel_board_one
		| sel_board_two
		| sel_alarm_one
		| sel_alarm_two;

	// Words are picked live in the request cycle so the answer shows current state
	assign pick_run_status = sel_run_status ? run_status_word : `WORD_RESET;
	assign pick_keypad = sel_keypad ? keypad_word : `WORD_RESET;
	assign pick_set_err = sel_set_err ? set_err_word : `WORD_RESET;
	assign pick_fault_one = sel_fault_one ? fault_one_word : `WORD_RESET;
	assign pick_fault_two = sel_fault_two ? fault_two_word : `WORD_RESET;
	assign pick_fault_three = sel_fault_three ? fault_three_word : `WORD_RESET;
	assign pick_board_one = sel_board_one ? board_one_word : `WORD_RESET;
	assign pick_board_two = sel_board_two ? board_two_word : `WORD_RESET;
	assign pick_alarm_one = sel_alarm_one ? alarm_one_word : `WORD_RESET;
	assign pick_alarm_two = sel_alarm_two ? alarm_two_word : `WORD_RESET;

	// Selects are one-hot, so an OR of the picks is the chosen word
	assign read_word = pick_run_status
		| pick_keypad
		| pick_set_err
		| pick_fault_one
		| pick_fault_two
		| pick_fault_three
		| pick_board_one
		| pick_board_two
		| pick_alarm_one
		| pick_alarm_two;

	// A write never touches a word; it is answered with the error flag and no data
	assign read_req = req.valid && !req.write;
	assign write_req = req.valid && req.write;
	assign rsp_next.valid = req.valid;
	assign rsp_next.error = write_req || (read_req && !addr_hit);
	assign rsp_next.rdata = read_req ? read_word : `WORD_RESET;

	// Answer is held while the clock enable is low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rsp_reg <= '0;
		end else if (clk_en) begin
			rsp_reg <= rsp_next;
		end
	end

	assign rsp = rsp_reg;
endmodule
`default_nettype wire

// [drive_monitor_status_bank_chk.sv]
// Checker of the monitor bank answer timing and word maps
`include "monitor_bank_params.svh"
`default_nettype none
module drive_monitor_status_bank_chk import monitor_bank_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire reg_req_type req,
	input wire reg_rsp_type rsp,
	input wire logic [15:0] run_status_src,
	input wire keypad_src_type keypad_src
);
	wire logic tk = req.valid && clk_en;
	wire logic rd = tk && !req.write;
	wire logic [15:0] kw = {11'h0, keypad_src.panel_type, keypad_src.programming_mode, keypad_src.in_fault,
		keypad_src.setting_error};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	chk_answer_strobe: assert property (tk |=> rsp.valid) else $error("no answer");
	chk_no_spurious: assert property (!tk && clk_en |=> !rsp.valid) else $error("stray answer");
	chk_write_refused: assert property (tk && req.write |=> rsp.error && rsp.rdata == 16'h0000)
		else $error("write not refused");
	chk_range_error: assert property (rd |=> rsp.error == $past(req.addr < `ADDR_RUN_STATUS ||
		req.addr > `ADDR_ALARM_TWO)) else $error("wrong error flag");
	chk_unused_word: assert property (rd && req.addr == `ADDR_UNUSED |=> rsp.rdata == 16'h0000)
		else $error("unused word not zero");
	chk_keypad_map: assert property (rd && req.addr == `ADDR_KEYPAD |=> rsp.rdata == $past(kw))
		else $error("keypad word wrong");
	chk_run_masked: assert property (rd && req.addr == `ADDR_RUN_STATUS |=>
		rsp.rdata == ($past(run_status_src) & `RUN_STATUS_MASK)) else $error("run word wrong");
	chk_fault_gaps: assert property (rd && req.addr == `ADDR_FAULT_THREE |=> (rsp.rdata & 16'hf82c) == 0)
		else $error("fault word three gap set");
	chk_alarm_gaps: assert property (rd && req.addr == `ADDR_ALARM_TWO |=> rsp.rdata[15:8] == 0 &&
		!rsp.rdata[0]) else $error("alarm word two gap set");
endmodule
bind drive_monitor_status_bank drive_monitor_status_bank_chk drive_monitor_status_bank_chk_inst (.sys_clk, .rst,
	.clk_en, .req, .rsp, .run_status_src, .keypad_src);
`default_nettype wire

// [serial_master_model.sv]
// Serial master stand-in issuing single word requests
`default_nettype none
module serial_master_model import monitor_bank_pkg::*; (
	input wire logic sys_clk,
	output var reg_req_type req,
	input wire reg_rsp_type rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req = '0;
	// Idle fields carry a changing pattern so a stale address is never mistaken for a request
	task automatic xfer(input logic [15:0] a, input logic w, output logic [15:0] d, output logic e);
		@(negedge sys_clk);
		req = '{1'b1, w, a, ~a};
		@(negedge sys_clk);
		d = rsp.rdata;
		e = rsp.error;
		req = '{1'b0, 1'b0, ~a, a};
	endtask
endmodule
`default_nettype wire

// [tb_drive_monitor_status_bank.sv]
// Self-checking bench of the drive monitor bank
`include "monitor_bank_params.svh"
`default_nettype none
module tb_drive_monitor_status_bank import monitor_bank_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	reg_req_type req;
	reg_rsp_type rsp;
	logic [15:0] run_s = '0, err_s = '0, b1_s = '0, b2_s = '0, d;
	logic e;
	keypad_src_type kp = '0;
	fault_src_type fs = '0;
	alarm_src_type al = '0;
	int mismatches = 0, compares = 0;
	always #20 sys_clk = ~sys_clk;
	drive_monitor_status_bank drive_monitor_status_bank_inst (.sys_clk, .rst, .clk_en, .req, .rsp,
		.run_status_src(run_s), .setting_error_number_src(err_s), .board_fault_one_src(b1_s),
		.board_fault_two_src(b2_s), .keypad_src(kp), .fault_src(fs), .alarm_src(al));
	serial_master_model serial_master_model_inst (.sys_clk, .req, .rsp);
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_cmp(input logic [15:0] a, input logic w, input logic [15:0] exp, input logic ee);
		serial_master_model_inst.xfer(a, w, d, e);
		cmp(d, exp);
		cmp({15'h0, e}, {15'h0, ee});
	endtask
	// One source flag at a time; map holds word and bit of each flag, LSB flag first
	task automatic walk(input int grp, input int n, input int nw, input logic [15:0] base, input logic [287:0] map);
		logic [7:0] c;
		for (int j = 0; j < n; j++) begin
			c = map[j*8 +: 8];
			fs = '0;
			al = '0;
			kp = '0;
			case (grp)
				0: fs = 36'h1 << j;
				1: al = 21'h1 << j;
				default: kp = 5'h1 << j;
			endcase
			for (int w = 1; w <= nw; w++)
				rd_cmp(base + w[15:0], 1'b0, (c[7:4] == w) ? 16'h1 << c[3:0] : 16'h0, 1'b0);
		end
	endtask
	task automatic all_ones();
		logic [175:0] t = 176'h00ff001fffff0000ffefdf9f07d3006c000f9fff00fe;
		run_s = '1;
		err_s = '1;
		b1_s = '1;
		b2_s = '1;
		fs = '1;
		al = '1;
		kp = '1;
		for (int k = 0; k < 11; k++)
			rd_cmp(16'h0010 + k[15:0], 1'b0, t[(10-k)*16 +: 16], 1'b0);
	endtask
	task automatic refusals();
		rd_cmp(`ADDR_FAULT_ONE, 1'b1, 16'h0000, 1'b1);
		rd_cmp(16'h000f, 1'b0, 16'h0000, 1'b1);
		rd_cmp(16'h001b, 1'b0, 16'h0000, 1'b1);
		rd_cmp(`ADDR_FAULT_ONE, 1'b0, 16'hffef, 1'b0);
	endtask
	task automatic freeze();
		rd_cmp(`ADDR_ALARM_ONE, 1'b0, 16'h9fff, 1'b0);
		clk_en = 1'b0;
		al = '0;
		repeat (3) @(negedge sys_clk);
		cmp({rsp.valid, 15'h0}, 16'h8000);
		cmp(rsp.rdata, 16'h9fff);
		clk_en = 1'b1;
		rd_cmp(`ADDR_ALARM_ONE, 1'b0, 16'h0000, 1'b0);
	endtask
	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		cmp(rsp.rdata | {rsp.valid, rsp.error, 14'h0}, 16'h0000);
		walk(0, 36, 3, 16'h0013,
			288'h1011121315161718191a1b1c1d1e1f242322212027_28292a2b2c2e2f303134363738393a);
		walk(1, 21, 2, 16'h0018,
			288'h10111213141516171c1b1a19181f212223242526_27);
		walk(2, 5, 1, 16'h0010, 288'h1011121413);
		all_ones();
		refusals();
		freeze();
		print_verdict();
	end
endmodule
`default_nettype wire
